// [rtl/cpt_exec.sv]
// Executor for pop-return, pair moves and table jumps, with the table CSR.
// Assumes a combinational register-file read and a memory port holding
// each request until acknowledged.
// Functional notes
// RULE_01: list code 4 is ra only, each higher adds a saved reg; 15 all twelve.
// RULE_02: frame size is base size plus two-bit immediate times 16.
// RULE_03: 32-bit base sizes 16/32/48/64 for codes 4-7/8-11/12-14/15.
// RULE_04: 64-bit base sizes 16 to 112 in pairs of codes, 96 and 112 last.
// RULE_05: loads start at sp+frame-width, order x27..x18,x9,x8,x1, step down.
// RULE_06: restore loads may run again after a trap before completion.
// RULE_07: sp update and return happen together after clean loads only.
// RULE_08: args-to-saved move is illegal when both selectors are equal.
// RULE_09: a0 and a1 go into the two saved registers in one update.
// RULE_10: the two saved registers go into a0 and a1 in one update.
// RULE_11: selector maps to register 8-9 or 18-23 by its upper bits.
// RULE_12: on reduced base, pair moves with a selector above 1 are reserved.
// RULE_13: table has 256 word entries, base aligned to 64 bytes.
// RULE_14: table entries are read in current data endianness.
// RULE_15: linking table jump pushes the return stack like jal ra.
// RULE_16: entry fetch is an instruction fetch needing execute permission.
// RULE_17: entry fetch should be hidden from triggers and breakpoints.
// RULE_18: fetch fault reports the jump's pc, fault cause and fetch address.
// RULE_19: table CSR at 0x017, user read/write, aligned base plus mode.
// RULE_20: only mode zero exists; reserved mode makes table jumps reserved.
// RULE_21: cleared state-enable bit 2 traps lower-privilege CSR and jumps.
// RULE_22: index below 32 is plain jump, 32 and above the linking one.
// RULE_23: entry address is base plus index shifted by 2 or 3.
// RULE_24: linking jump writes ra; target has bit zero cleared.
`timescale 1ns/100ps
module cpt_exec
  import cpt_pkg::*;
(
  input  wire logic        clk,             // Core clock
  input  wire logic        rst_n,           // Sync reset
  input  wire logic        reduced_base,    // 16-register base
  input  wire logic        stateen_present, // State-enable present
  input  wire logic        stateen_tj_en,   // Controlling bit 2
  input  wire logic        lower_priv,      // Below controlling level
  input  wire logic        virt_mode,       // Virtualised level
  input  wire logic        data_big_endian, // Data endianness
  input  wire logic        intr_pending,    // Interrupt waiting
  input  wire logic        req_valid,       // Request strobe
  input  wire cpt_req_t    req,             // Decoded instruction
  output logic             req_ready,       // Idle
  output logic [4:0]       rf_rd_addr1,     // Read port 1
  output logic [4:0]       rf_rd_addr2,     // Read port 2
  input  wire logic [31:0] rf_rd_data1,     // Read data 1
  input  wire logic [31:0] rf_rd_data2,     // Read data 2
  output cpt_wr_t          rf_wr1,          // Write port 1
  output cpt_wr_t          rf_wr2,          // Write port 2
  output cpt_mem_t         mem_req,         // Memory request
  input  wire logic        mem_ack,         // Memory answer
  input  wire logic        mem_fault,       // Access failed
  input  wire logic        mem_fault_page,  // Failure is page fault
  input  wire logic [31:0] mem_rdata,       // Memory data
  output logic             redirect_valid,  // Jump strobe
  output logic [31:0]      redirect_pc,     // Jump target
  output logic             ras_push,        // Return stack push
  output logic             done,            // Completion pulse
  output cpt_res_t         result,          // Completion code
  output logic [31:0]      trap_pc,         // Trap pc value
  output logic [4:0]       trap_cause,      // Trap reason value
  output logic [31:0]      trap_val,        // Trap value
  input  wire logic        csr_valid,       // CSR access strobe
  input  wire logic        csr_we,          // CSR write
  input  wire logic [11:0] csr_addr,        // CSR address
  input  wire logic [31:0] csr_wdata,       // CSR write data
  output logic             csr_done,        // CSR answer pulse
  output logic             csr_illegal,     // CSR access trapped
  output logic [31:0]      csr_rdata        // CSR read data
);

  typedef enum logic [2:0] {ST_IDLE, ST_READ, ST_LOAD, ST_WAIT, ST_TJWAIT} cpt_state_t;

  //////////////////////////////////////////////////////////////////////////
  // Decoding helpers

  function automatic logic [4:0] sel_reg(input logic [2:0] s);
    sel_reg = {|s[2:1], ~|s[2:1], s}; // RULE_11
  endfunction

  function automatic logic [7:0] frame_base(input logic [3:0] r, input logic wide);
    if (wide) begin // RULE_04
      if (r <= 4'h5) frame_base = 8'h10;
      else if (r <= 4'h7) frame_base = 8'h20;
      else if (r <= 4'h9) frame_base = 8'h30;
      else if (r <= 4'hb) frame_base = 8'h40;
      else if (r <= 4'hd) frame_base = 8'h50;
      else if (r == 4'he) frame_base = 8'h60;
      else frame_base = 8'h70;
    end else begin // RULE_03
      if (r <= 4'h7) frame_base = 8'h10;
      else if (r <= 4'hb) frame_base = 8'h20;
      else if (r <= 4'he) frame_base = 8'h30;
      else frame_base = 8'h40;
    end
  endfunction

  function automatic logic [4:0] slot_reg(input logic [3:0] j);
    if (j < 4'ha) slot_reg = 5'(5'd27 - {1'b0, j}); // RULE_05
    else if (j == 4'ha) slot_reg = 5'd9;
    else if (j == 4'hb) slot_reg = 5'd8;
    else slot_reg = REG_RA;
  endfunction

  function automatic logic slot_on(input logic [3:0] j, input logic [3:0] r);
    logic [3:0] n;
    logic [3:0] sidx;
    n = (r == RLIST_ALL) ? 4'hc : 4'(r - RLIST_MIN); // RULE_01
    sidx = (j < 4'ha) ? 4'(4'hb - j) : 4'(4'hb - j);
    slot_on = (j == SLOT_RA) || (sidx < n);
  endfunction

  //////////////////////////////////////////////////////////////////////////
  // Registers

  cpt_state_t  state_r;
  cpt_req_t    req_r;
  logic [7:0]  adj_r;
  logic [3:0]  slot_r;
  logic [31:0] addr_r;
  logic [31:0] ra_r;
  logic [4:0]  dst1_r;
  logic [4:0]  dst2_r;
  logic [25:0] tj_base_r;
  logic [5:0]  tj_mode_r;

  logic [7:0]  adj_w;
  logic        tj_gated_w;
  logic        mv_bad_w;
  logic [31:0] entry_w;

  assign adj_w      = 8'(frame_base(req.rlist, XLEN == 64) + {2'b00, req.spimm, 4'h0}); // RULE_02
  assign tj_gated_w = stateen_present && lower_priv && !stateen_tj_en; // RULE_21
  assign mv_bad_w   = ((req.op == CPT_OP_MVSA) && (req.sel1 == req.sel2)) // RULE_08
                   || (reduced_base && ((req.sel1 > 3'h1) || (req.sel2 > 3'h1))); // RULE_12
  assign entry_w    = data_big_endian ? {mem_rdata[7:0], mem_rdata[15:8], mem_rdata[23:16], mem_rdata[31:24]} // RULE_14
                                      : mem_rdata;

  //////////////////////////////////////////////////////////////////////////
  // Sequencer

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_r        <= ST_IDLE;
      req_r          <= '0;
      adj_r          <= 8'h00;
      slot_r         <= 4'h0;
      addr_r         <= 32'h0;
      ra_r           <= 32'h0;
      dst1_r         <= 5'h00;
      dst2_r         <= 5'h00;
      req_ready      <= 1'b0;
      rf_rd_addr1    <= 5'h00;
      rf_rd_addr2    <= 5'h00;
      rf_wr1         <= '0;
      rf_wr2         <= '0;
      mem_req        <= '0;
      redirect_valid <= 1'b0;
      redirect_pc    <= 32'h0;
      ras_push       <= 1'b0;
      done           <= 1'b0;
      result         <= CPT_RES_OK;
      trap_pc        <= 32'h0;
      trap_cause     <= 5'h00;
      trap_val       <= 32'h0;
    end else begin
      done           <= 1'b0;
      redirect_valid <= 1'b0;
      ras_push       <= 1'b0;
      rf_wr1.en      <= 1'b0;
      rf_wr2.en      <= 1'b0;
      unique case (state_r)
        ST_IDLE: begin
          req_ready <= 1'b1;
          if (req_valid && req_ready) begin
            req_ready <= 1'b0;
            req_r     <= req;
            trap_pc   <= req.pc;
            trap_val  <= 32'h0;
            unique case (req.op)
              CPT_OP_POPRET: begin
                if (req.rlist < RLIST_MIN) begin // RULE_01
                  done       <= 1'b1;
                  result     <= CPT_RES_ILL;
                  trap_cause <= CAUSE_ILL;
                  state_r    <= ST_IDLE;
                end else begin
                  adj_r   <= adj_w;
                  addr_r  <= 32'(req.sp + {24'h0, adj_w} - XBYTES); // RULE_05
                  slot_r  <= 4'h0;
                  state_r <= ST_LOAD;
                end
              end
              CPT_OP_MVSA, CPT_OP_MVAS: begin
                if (mv_bad_w) begin
                  done       <= 1'b1;
                  result     <= CPT_RES_ILL;
                  trap_cause <= CAUSE_ILL;
                  state_r    <= ST_IDLE;
                end else begin
                  if (req.op == CPT_OP_MVSA) begin
                    rf_rd_addr1 <= REG_A0; // RULE_09
                    rf_rd_addr2 <= REG_A1;
                    dst1_r      <= sel_reg(req.sel1);
                    dst2_r      <= sel_reg(req.sel2);
                  end else begin
                    rf_rd_addr1 <= sel_reg(req.sel1); // RULE_10
                    rf_rd_addr2 <= sel_reg(req.sel2);
                    dst1_r      <= REG_A0;
                    dst2_r      <= REG_A1;
                  end
                  state_r <= ST_READ;
                end
              end
              CPT_OP_TJ: begin
                if (tj_gated_w || (tj_mode_r != TJ_MODE_JT)) begin // RULE_20 RULE_21
                  done       <= 1'b1;
                  result     <= CPT_RES_ILL;
                  trap_cause <= (tj_gated_w && virt_mode) ? CAUSE_VIRT : CAUSE_ILL;
                  state_r    <= ST_IDLE;
                end else begin
                  mem_req.valid   <= 1'b1;
                  mem_req.fetch   <= 1'b1; // RULE_16
                  mem_req.no_trig <= 1'b1; // RULE_17
                  mem_req.addr    <= {tj_base_r, 6'h00} + {22'h0, req.index, 2'b00}; // RULE_13 RULE_23
                  state_r         <= ST_TJWAIT;
                end
              end
            endcase
          end
        end
        ST_READ: begin
          rf_wr1  <= '{en: 1'b1, addr: dst1_r, data: rf_rd_data1}; // RULE_09 RULE_10
          rf_wr2  <= '{en: 1'b1, addr: dst2_r, data: rf_rd_data2};
          done    <= 1'b1;
          result  <= CPT_RES_OK;
          state_r <= ST_IDLE;
        end
        ST_LOAD: begin
          if (intr_pending) begin // RULE_06
            done    <= 1'b1;
            result  <= CPT_RES_ABORT;
            state_r <= ST_IDLE;
          end else if (slot_r == N_SLOTS) begin
            rf_wr1         <= '{en: 1'b1, addr: REG_SP, data: 32'(req_r.sp + {24'h0, adj_r})}; // RULE_07
            redirect_valid <= 1'b1;
            redirect_pc    <= {ra_r[31:1], 1'b0};
            done           <= 1'b1;
            result         <= CPT_RES_OK;
            state_r        <= ST_IDLE;
          end else if (slot_on(slot_r, req_r.rlist)) begin
            mem_req <= '{valid: 1'b1, fetch: 1'b0, no_trig: 1'b0, addr: addr_r};
            state_r <= ST_WAIT;
          end else begin
            slot_r <= 4'(slot_r + 4'h1);
          end
        end
        ST_WAIT: begin
          if (mem_ack) begin
            mem_req.valid <= 1'b0;
            if (mem_fault) begin
              done       <= 1'b1;
              result     <= CPT_RES_FAULT;
              trap_cause <= mem_fault_page ? CAUSE_LPAGE : CAUSE_LACC;
              trap_val   <= mem_req.addr;
              state_r    <= ST_IDLE;
            end else begin
              rf_wr1 <= '{en: 1'b1, addr: slot_reg(slot_r), data: mem_rdata};
              if (slot_r == SLOT_RA) ra_r <= mem_rdata;
              addr_r  <= 32'(addr_r - XBYTES); // RULE_05
              slot_r  <= 4'(slot_r + 4'h1);
              state_r <= ST_LOAD;
            end
          end
        end
        ST_TJWAIT: begin
          if (mem_ack) begin
            mem_req.valid <= 1'b0;
            done          <= 1'b1;
            state_r       <= ST_IDLE;
            if (mem_fault) begin // RULE_18
              result     <= CPT_RES_FAULT;
              trap_cause <= mem_fault_page ? CAUSE_IPAGE : CAUSE_IACC;
              trap_val   <= mem_req.addr;
            end else begin
              result         <= CPT_RES_OK;
              redirect_valid <= 1'b1;
              redirect_pc    <= {entry_w[31:1], 1'b0}; // RULE_24
              if (req_r.index >= TJ_LINK_MIN) begin // RULE_22
                rf_wr1   <= '{en: 1'b1, addr: REG_RA, data: 32'(req_r.pc + C_INSN_LEN)}; // RULE_24
                ras_push <= 1'b1; // RULE_15
              end
            end
          end
        end
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Table CSR

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      tj_base_r   <= TJ_RESET[31:6];
      tj_mode_r   <= TJ_RESET[5:0];
      csr_done    <= 1'b0;
      csr_illegal <= 1'b0;
      csr_rdata   <= 32'h0;
    end else begin
      csr_done    <= 1'b0;
      csr_illegal <= 1'b0;
      if (csr_valid && (csr_addr == CSR_TJ_ADDR)) begin // RULE_19
        csr_done <= 1'b1;
        if (tj_gated_w) begin // RULE_21
          csr_illegal <= 1'b1;
          csr_rdata   <= 32'h0;
        end else begin
          csr_rdata <= {tj_base_r, tj_mode_r};
          if (csr_we) begin
            tj_base_r <= csr_wdata[31:6]; // RULE_13
            if (csr_wdata[TJ_MODE_W-1:0] == TJ_MODE_JT) tj_mode_r <= TJ_MODE_JT; // RULE_20
          end
        end
      end
    end
  end

endmodule // cpt_exec

// [rtl/cpt_pkg.sv]
// Constants and carriers for the compressed pop/move/table-jump executor.
// Assumes a 32-bit hart; one clock, synchronous reset.
package cpt_pkg;

  localparam int          XLEN         = 32;
  localparam int          XBYTES       = XLEN / 8;
  localparam logic [11:0] CSR_TJ_ADDR  = 12'h017;
  localparam int          TJ_MODE_W    = 6;
  localparam logic [5:0]  TJ_MODE_JT   = 6'h00;
  localparam logic [31:0] TJ_RESET     = 32'h0000_0000;
  localparam logic [4:0]  REG_RA       = 5'h01;
  localparam logic [4:0]  REG_SP       = 5'h02;
  localparam logic [4:0]  REG_A0       = 5'h0a;
  localparam logic [4:0]  REG_A1       = 5'h0b;
  localparam logic [3:0]  RLIST_MIN    = 4'h4;
  localparam logic [3:0]  RLIST_ALL    = 4'hf;
  localparam logic [3:0]  N_SLOTS      = 4'hd;
  localparam logic [3:0]  SLOT_RA      = 4'hc;
  localparam logic [7:0]  TJ_LINK_MIN  = 8'h20;
  localparam logic [31:0] C_INSN_LEN   = 32'h0000_0002;
  localparam logic [4:0]  CAUSE_IACC   = 5'h01;
  localparam logic [4:0]  CAUSE_ILL    = 5'h02;
  localparam logic [4:0]  CAUSE_LACC   = 5'h05;
  localparam logic [4:0]  CAUSE_IPAGE  = 5'h0c;
  localparam logic [4:0]  CAUSE_LPAGE  = 5'h0d;
  localparam logic [4:0]  CAUSE_VIRT   = 5'h16;

  typedef enum logic [1:0] {CPT_OP_POPRET, CPT_OP_MVSA, CPT_OP_MVAS, CPT_OP_TJ} cpt_op_t;
  typedef enum logic [1:0] {CPT_RES_OK, CPT_RES_ILL, CPT_RES_FAULT, CPT_RES_ABORT} cpt_res_t;

  typedef struct packed {
    cpt_op_t     op;
    logic [3:0]  rlist;
    logic [1:0]  spimm;
    logic [2:0]  sel1;
    logic [2:0]  sel2;
    logic [7:0]  index;
    logic [31:0] pc;
    logic [31:0] sp;
  } cpt_req_t;

  typedef struct packed {
    logic        valid;
    logic        fetch;
    logic        no_trig;
    logic [31:0] addr;
  } cpt_mem_t;

  typedef struct packed {
    logic        en;
    logic [4:0]  addr;
    logic [31:0] data;
  } cpt_wr_t;

endpackage

// [tb/cpt_exec_properties.sv]
// Timing checks on the executor's ports.
// Assumes one clock and a synchronous active-low reset.
`timescale 1ns/100ps
module cpt_exec_properties
  import cpt_pkg::*;
(
  input wire logic        clk,            // Core clock
  input wire logic        rst_n,          // Sync reset
  input wire logic        req_valid,      // Request strobe
  input wire cpt_req_t    req,            // Decoded instruction
  input wire logic        req_ready,      // Idle
  input wire cpt_wr_t     rf_wr1,         // Write port 1
  input wire cpt_wr_t     rf_wr2,         // Write port 2
  input wire cpt_mem_t    mem_req,        // Memory request
  input wire logic        redirect_valid, // Jump strobe
  input wire logic [31:0] redirect_pc,    // Jump target
  input wire logic        ras_push,       // Return stack push
  input wire logic        done,           // Completion pulse
  input wire cpt_res_t    result,         // Completion code
  input wire logic [31:0] trap_pc,        // Trap pc
  input wire logic        csr_valid,      // CSR strobe
  input wire logic [11:0] csr_addr,       // CSR address
  input wire logic        csr_done,       // CSR answer
  input wire logic        csr_illegal     // CSR trapped
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  cpt_op_t     op_q;
  logic [31:0] pc_q;
  always_ff @(posedge clk) begin
    if (req_valid && req_ready) begin
      op_q <= req.op;
      pc_q <= req.pc;
    end
  end
  ////////////////////////////////////////////////////////////
  sequence s_take;
    req_valid && req_ready;
  endsequence
  sequence s_mvas_take;
    s_take ##0 req.op == CPT_OP_MVAS;
  endsequence
  property p_pair;
    rf_wr2.en |-> rf_wr1.en && done && result == CPT_RES_OK;
  endproperty
  a_pair: assert property (p_pair) else $error("second write without first");
  property p_mvas_dst;
    done && op_q == CPT_OP_MVAS && result == CPT_RES_OK |-> rf_wr1.addr == REG_A0 && rf_wr2.addr == REG_A1;
  endproperty
  a_mvas_dst: assert property (p_mvas_dst) else $error("move to args wrong target");
  property p_mv_time;
    s_mvas_take |-> ##[1:2] done;
  endproperty
  a_mv_time: assert property (p_mv_time) else $error("move did not complete");
  property p_sp_ret;
    rf_wr1.en && rf_wr1.addr == REG_SP |-> redirect_valid && done && result == CPT_RES_OK;
  endproperty
  a_sp_ret: assert property (p_sp_ret) else $error("sp write apart from return");
  property p_ras;
    ras_push |-> redirect_valid && rf_wr1.en && rf_wr1.addr == REG_RA;
  endproperty
  a_ras: assert property (p_ras) else $error("push without link");
  property p_lsb;
    redirect_valid |-> !redirect_pc[0];
  endproperty
  a_lsb: assert property (p_lsb) else $error("target bit zero set");
  property p_fetch;
    mem_req.valid |-> mem_req.fetch == (op_q == CPT_OP_TJ) && mem_req.addr[1:0] == 2'b00;
  endproperty
  a_fetch: assert property (p_fetch) else $error("fetch kind or alignment wrong");
  property p_notrig;
    mem_req.valid && mem_req.fetch |-> mem_req.no_trig;
  endproperty
  a_notrig: assert property (p_notrig) else $error("entry fetch visible to triggers");
  property p_fault_pc;
    done && result == CPT_RES_FAULT |-> trap_pc == pc_q && !redirect_valid;
  endproperty
  a_fault_pc: assert property (p_fault_pc) else $error("fault pc wrong");
  property p_csr;
    csr_valid && csr_addr == CSR_TJ_ADDR |=> csr_done || csr_illegal;
  endproperty
  a_csr: assert property (p_csr) else $error("table register not answered");
endmodule // cpt_exec_properties

bind cpt_exec cpt_exec_properties u_props (.*);

// [tb/cpt_mem_model.sv]
// Memory model answering stack-frame and jump-table reads with address-derived data.
// Assumes requests are held until the cycle after the answer.
`timescale 1ns/100ps
module cpt_mem_model
  import cpt_pkg::*;
(
  input  wire logic        clk,       // Core clock
  input  wire cpt_mem_t    mem_req,   // Request
  input  wire logic [3:0]  lat,       // Wait cycles
  input  wire logic [31:0] bad_addr,  // Faulting address
  output logic             mem_ack,   // Answer pulse
  output logic             mem_fault, // Access failed
  output logic [31:0]      mem_rdata  // Read data
);
  logic [3:0]  cnt_r = 4'h0;
  logic        seen_r = 1'b0;
  logic [31:0] last_r = 32'h0;
  initial begin
    mem_ack = 1'b0;
    mem_fault = 1'b0;
    mem_rdata = 32'h0;
  end
  always @(posedge clk) begin
    mem_ack <= 1'b0;
    mem_fault <= 1'b0;
    mem_rdata <= ~mem_rdata;
    if (!mem_req.valid)
      seen_r <= 1'b0;
    if (!mem_req.valid || (seen_r && mem_req.addr == last_r))
      cnt_r <= 4'h0;
    else if (cnt_r < lat)
      cnt_r <= cnt_r + 4'h1;
    else begin
      cnt_r <= 4'h0;
      seen_r <= 1'b1;
      last_r <= mem_req.addr;
      mem_ack <= 1'b1;
      mem_fault <= mem_req.addr == bad_addr;
      mem_rdata <= {mem_req.addr[15:0], ~mem_req.addr[15:0]};
    end
  end
endmodule // cpt_mem_model

// [tb/cpt_exec_tb.sv]
// Self-checking bench for the pop-return, pair-move and table-jump executor.
// Assumes the memory model and a combinational register file beside it.
`timescale 1ns/100ps
module cpt_exec_tb;
  import cpt_pkg::*;
  localparam logic [31:0] SPV = 32'h0000_8000, PCV = 32'h0000_0400;
  localparam logic [31:0] TBASE = 32'h0000_2000, NONE = 32'hffff_ffff;
  typedef struct {cpt_op_t op; logic [2:0] s1, s2; logic [4:0] r1, r2;} cpt_row_t;
  cpt_row_t rows[4] = '{'{CPT_OP_MVSA, 3'h0, 3'h1, 5'h08, 5'h09}, '{CPT_OP_MVSA, 3'h7, 3'h2, 5'h17, 5'h12},
                        '{CPT_OP_MVAS, 3'h3, 3'h6, 5'h13, 5'h16}, '{CPT_OP_MVAS, 3'h5, 3'h5, 5'h15, 5'h15}};
  int          ord_c[13] = '{27, 26, 25, 24, 23, 22, 21, 20, 19, 18, 9, 8, 1};
  logic [5:0]  pops[6] = '{6'h04, 6'h39, 6'h1f, 6'h2c, 6'h0b, 6'h0e};
  logic [8:0]  tjs[4] = '{9'h005, 9'h11f, 9'h020, 9'h1ff};
  logic clk = 1'b0, rst_n = 1'b0, reduced_base = 1'b0, stateen_present = 1'b0, stateen_tj_en = 1'b1;
  logic lower_priv = 1'b0, virt_mode = 1'b0, data_big_endian = 1'b0, intr_pending = 1'b0, req_valid = 1'b0;
  logic csr_valid = 1'b0, csr_we = 1'b0, mem_fault_page = 1'b0, mem_ack, mem_fault;
  logic req_ready, redirect_valid, ras_push, done, csr_done, csr_illegal;
  logic [3:0]  lat = 4'h0;
  logic [4:0]  rf_rd_addr1, rf_rd_addr2, trap_cause;
  logic [11:0] csr_addr = 12'h000;
  logic [31:0] csr_wdata = 32'h0, bad_addr = 32'hffff_ffff, rf_rd_data1, rf_rd_data2;
  logic [31:0] mem_rdata, redirect_pc, trap_pc, trap_val, csr_rdata;
  cpt_req_t    req = '0;
  cpt_wr_t     rf_wr1, rf_wr2;
  cpt_mem_t    mem_req;
  cpt_res_t    result;
  int          fails = 0, checks_done = 0, cyc = 0;
  cpt_exec dut_u (.*);
  cpt_mem_model mem_u (.*);
  function automatic logic [31:0] rfv(logic [4:0] a);
    return 32'hc0de_0000 | 32'(a);
  endfunction
  function automatic logic [31:0] memv(logic [31:0] a);
    return {a[15:0], ~a[15:0]};
  endfunction
  function automatic bit listed(logic [3:0] rl, int r);
    return r == 1 || (r == 8 && rl >= 5) || (r == 9 && rl >= 6) || (r >= 18 && (rl >= r - 11 || rl == 15));
  endfunction
  assign rf_rd_data1 = rfv(rf_rd_addr1);
  assign rf_rd_data2 = rfv(rf_rd_addr2);
  always #10 clk = ~clk;
  ////////////////////////////////////////////////////////////
  task automatic stop_test();
    if (fails == 0 && checks_done > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      fails++;
      stop_test();
    end
  end
  task automatic tick();
    @(posedge clk);
    #2;
  endtask
  task automatic chk(string nm, logic [127:0] got, logic [127:0] exp);
    checks_done++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic wait_done(cpt_res_t exp);
    for (int i = 0; i < 300 && done !== 1'b1; i++)
      tick();
    chk("result", {done, result}, {1'b1, exp});
  endtask
  task automatic issue(cpt_op_t op, logic [3:0] rl, logic [1:0] im, logic [2:0] s1, logic [2:0] s2, logic [7:0] ix);
    while (req_ready !== 1'b1)
      tick();
    req = '{op, rl, im, s1, s2, ix, PCV, SPV};
    req_valid = 1'b1;
    tick();
    req_valid = 1'b0;
  endtask
  task automatic csr(logic we, logic [11:0] ad, logic [31:0] wd);
    tick();
    csr_valid = 1'b1;
    csr_we = we;
    csr_addr = ad;
    csr_wdata = wd;
    tick();
    csr_valid = 1'b0;
  endtask
  task automatic pop(logic [3:0] rl, logic [1:0] im, logic [31:0] bad, cpt_res_t exp);
    logic [31:0] fr, a;
    int k, n;
    fr = (rl < 8 ? 16 : rl < 12 ? 32 : rl < 15 ? 48 : 64) + 16 * im;
    a = SPV + fr - 32'd4;
    k = 0;
    n = 0;
    bad_addr = bad;
    issue(CPT_OP_POPRET, rl, im, 3'h0, 3'h0, 8'h00);
    for (int i = 0; i < 300 && done !== 1'b1; i++) begin
      tick();
      if (rf_wr1.en === 1'b1 && rf_wr1.addr !== REG_SP) begin
        while (k < 12 && !listed(rl, ord_c[k]))
          k++;
        chk("pop load", {rf_wr1.addr, rf_wr1.data}, {5'(ord_c[k]), memv(a)});
        a -= 32'd4;
        k++;
        n++;
      end
    end
    chk("pop result", {done, result}, {1'b1, exp});
    if (exp == CPT_RES_OK)
      chk("pop end", {n, rf_wr1.en, rf_wr1.addr, rf_wr1.data, redirect_valid, redirect_pc},
          {32'(rl == 15 ? 13 : rl - 3), 1'b1, REG_SP, SPV + fr, 1'b1, memv(a + 32'd4) & ~32'h1});
    else
      chk("pop fault", {trap_cause, trap_val, trap_pc}, {mem_fault_page ? CAUSE_LPAGE : CAUSE_LACC, bad, PCV});
  endtask
  task automatic tj(logic [7:0] ix, logic big, logic [31:0] bad, cpt_res_t exp);
    logic [31:0] a, e;
    a = TBASE + {22'h0, ix, 2'b00};
    e = memv(a);
    if (big)
      e = {e[7:0], e[15:8], e[23:16], e[31:24]};
    data_big_endian = big;
    bad_addr = bad;
    issue(CPT_OP_TJ, 4'h0, 2'h0, 3'h0, 3'h0, ix);
    wait_done(exp);
    if (exp == CPT_RES_OK) begin
      chk("jump", {redirect_valid, ras_push, redirect_pc}, {1'b1, ix >= 8'h20, e & ~32'h1});
      if (ix >= 8'h20)
        chk("link", {rf_wr1.en, rf_wr1.addr, rf_wr1.data}, {1'b1, REG_RA, PCV + C_INSN_LEN});
    end else if (exp == CPT_RES_FAULT)
      chk("jump fault", {trap_cause, trap_pc, trap_val}, {mem_fault_page ? CAUSE_IPAGE : CAUSE_IACC, PCV, a});
  endtask
  ////////////////////////////////////////////////////////////
  initial begin
    repeat (3) tick();
    chk("ready in reset", req_ready, 1'b0);
    rst_n = 1'b1;
    csr(1'b0, CSR_TJ_ADDR, 32'h0);
    chk("table reset", {csr_done, csr_rdata}, {1'b1, TJ_RESET});
    csr(1'b1, CSR_TJ_ADDR, TBASE | 32'h15);
    csr(1'b0, CSR_TJ_ADDR, 32'h0);
    chk("table read", csr_rdata, TBASE);
    csr(1'b0, 12'h018, 32'h0);
    chk("unmapped", csr_done, 1'b0);
    foreach (rows[i]) begin
      issue(rows[i].op, 4'h0, 2'h0, rows[i].s1, rows[i].s2, 8'h00);
      wait_done(CPT_RES_OK);
      chk("move", {rf_wr1.en, rf_wr2.en, rf_wr1.addr, rf_wr2.addr, rf_wr1.data, rf_wr2.data},
          rows[i].op == CPT_OP_MVSA ? {2'b11, rows[i].r1, rows[i].r2, rfv(REG_A0), rfv(REG_A1)}
                                    : {2'b11, REG_A0, REG_A1, rfv(rows[i].r1), rfv(rows[i].r2)});
    end
    issue(CPT_OP_MVSA, 4'h0, 2'h0, 3'h4, 3'h4, 8'h00);
    wait_done(CPT_RES_ILL);
    reduced_base = 1'b1;
    issue(CPT_OP_MVAS, 4'h0, 2'h0, 3'h1, 3'h2, 8'h00);
    wait_done(CPT_RES_ILL);
    issue(CPT_OP_MVSA, 4'h0, 2'h0, 3'h1, 3'h0, 8'h00);
    wait_done(CPT_RES_OK);
    reduced_base = 1'b0;
    issue(CPT_OP_POPRET, 4'h3, 2'h0, 3'h0, 3'h0, 8'h00);
    wait_done(CPT_RES_ILL);
    foreach (pops[i]) begin
      lat = 4'(i);
      pop(pops[i][3:0], pops[i][5:4], NONE, CPT_RES_OK);
    end
    pop(4'h7, 2'h1, SPV + 32'd24, CPT_RES_FAULT);
    intr_pending = 1'b1;
    issue(CPT_OP_POPRET, 4'h7, 2'h1, 3'h0, 3'h0, 8'h00);
    wait_done(CPT_RES_ABORT);
    chk("abort", {rf_wr1.en, redirect_valid}, 2'b00);
    intr_pending = 1'b0;
    pop(4'h7, 2'h1, NONE, CPT_RES_OK);
    foreach (tjs[i]) begin
      lat = 4'(i);
      tj(tjs[i][7:0], tjs[i][8], NONE, CPT_RES_OK);
    end
    tj(8'h21, 1'b0, TBASE + 32'd132, CPT_RES_FAULT);
    mem_fault_page = 1'b1;
    tj(8'h03, 1'b0, TBASE + 32'd12, CPT_RES_FAULT);
    pop(4'h4, 2'h0, SPV + 32'd12, CPT_RES_FAULT);
    mem_fault_page = 1'b0;
    stateen_present = 1'b1;
    stateen_tj_en = 1'b0;
    lower_priv = 1'b1;
    csr(1'b1, CSR_TJ_ADDR, 32'h0);
    chk("gated access", csr_illegal, 1'b1);
    tj(8'h02, 1'b0, NONE, CPT_RES_ILL);
    chk("gated cause", trap_cause, CAUSE_ILL);
    virt_mode = 1'b1;
    tj(8'h22, 1'b0, NONE, CPT_RES_ILL);
    chk("virtual cause", trap_cause, CAUSE_VIRT);
    stop_test();
  end
endmodule // cpt_exec_tb
